// ---- hw/tcx_switch.sv ----
// timeslot crosspoint switch: serial tdm streams, data and connection memories, host port
`timescale 1ns/1ns
`include "tcx_defs.svh"

// How it works
// - streams run at 2.048 Mbit/s in frames of about 8000 per second.
// - each frame holds exactly 256 one-bit intervals per stream.
// - frame bits group into 32 channels of eight bits, 64 kbit/s each.
// - channels are counted from frame start, zero up to 31.
// - bit timing from active-low 4.096 MHz clock, alignment from active-low frame pulse.
// - data is placed and taken per timeslot in step with clock and frame pulse.
// - switching mode fills each output channel from any input channel it names.
// - many output channels may name the same input channel for broadcast.
// - message mode sends the host-written byte every frame until rewritten.
// - host may read any input channel at any time, in any mode.
// - full size has eight input and eight output streams, 256 channels.
// - reduced size has four streams each way and no channel control output.
// - each output channel can be put in high impedance on its own.
// - host port has eight-bit two-way data and six address inputs.
// - a new host cycle is taken only while chip select is low; one already taken ends on the strobe alone.
// - host data is neither driven nor taken unless the strobe is high.
// - data is valid on the bus at the strobe's falling edge.
// - acknowledge goes low when the device is ready; host holds strobe till then.
// - after the strobe falls the acknowledge returns high, ending the cycle.
// - direction high means host read, low means host write.
// - address bit 5 low reaches control; high reaches block, segment and byte.
// - high connection bit 0 low makes the channel high impedance, else driven.
// - high connection bit 2 picks switched input byte or the low byte itself.
// - control bit 6 forces message mode and ignores per-channel mode and drive.
module tcx_switch #(
	parameter int STREAMS = `TCX_FULL_STREAMS
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   bitClock4xN,
	input  wire logic                   framePulseN,
	input  wire logic [7:0]             serialInStream,
	output logic      [7:0]             serialOutStream,
	output logic      [7:0]             serialOutOe,
	output logic      [7:0]             extChannelCtrlOut,
	input  wire tcx_pkg::tcx_host_req_t hostReq,
	output tcx_pkg::tcx_host_rsp_t      hostRsp
);

	localparam logic FULL_SIZE = (STREAMS == `TCX_FULL_STREAMS);

	// frame timing, two counts per bit interval
	logic                   clkPrev_q;
	logic [8:0]             halfCnt_q;
	logic [8:0]             halfCnt_d;
	logic                   clkFall;
	logic [4:0]             chanNum;
	logic [2:0]             bitNum;
	logic                   bitStart;
	logic                   bitMid;
	logic                   chanStart;

	// memories
	logic [7:0]             dataMem_q  [256];
	logic [7:0]             connLow_q  [256];
	logic [2:0]             connHigh_q [256];
	logic [7:0]             controlReg_q;

	// serial paths
	logic [6:0]             rxShift_q  [8];
	logic [7:0]             txShift_q  [8];
	logic [7:0]             txOe_q;
	logic [7:0]             txCtrl_q;
	logic [7:0]             txLoad     [8];
	logic [7:0]             txDrive;
	logic [7:0]             txCtrlNext;

	// host port
	tcx_pkg::tcx_host_state_t hostState_q;
	logic                   isRead_q;
	logic [5:0]             addr_q;
	logic [7:0]             wrData_q;
	logic [7:0]             rdData_q;
	logic                   hostStart;
	logic                   hostEnd;
	logic [1:0]             rdBlock;
	logic [1:0]             wrBlock;
	logic [7:0]             hostIndex;
	logic [7:0]             rdValue;
	logic [7:0]             wrIndex;
	logic                   wrCommit;
	logic                   ackOutN;
	logic                   driveData;

	function automatic logic [1:0] pickBlock(input logic [7:0] ctrl, input logic isRead);
		logic [1:0] blk;
		blk = ctrl[`TCX_CTRL_BLK_HI:`TCX_CTRL_BLK_LO];
		if (ctrl[`TCX_CTRL_SPLIT_BIT])
		begin
			blk = isRead ? `TCX_BLK_DATA : `TCX_BLK_CONN_LOW;
		end
		return blk;
	endfunction : pickBlock

	function automatic logic [7:0] chanIndex(input logic [2:0] stream, input logic [4:0] chan);
		logic [7:0] idx;
		idx = {stream, chan};
		// reduced size has only 128 locations, so the top segment bit is dropped
		if (!FULL_SIZE)
		begin
			idx[7] = 1'b0;
		end
		return idx;
	endfunction : chanIndex

	// frame and bit position
	assign clkFall   = clkPrev_q & ~bitClock4xN;
	assign halfCnt_d = framePulseN ? 9'(halfCnt_q + 9'h001) : 9'h000;
	assign chanNum   = halfCnt_d[8:4];
	assign bitNum    = halfCnt_d[3:1];
	assign bitStart  = clkFall & ~halfCnt_d[0];
	assign bitMid    = clkFall & halfCnt_d[0];
	assign chanStart = bitStart & (halfCnt_d[3:0] == `TCX_CHAN_START);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			clkPrev_q <= 1'b1;
			halfCnt_q <= 9'h000;
		end
		else
		begin
			clkPrev_q <= bitClock4xN;
			if (clkFall)
			begin
				halfCnt_q <= halfCnt_d;
			end
		end
	end

	// receive side: bytes go into data memory only once all eight bits are in
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < 8; s++)
			begin
				rxShift_q[s] <= 7'h00;
			end
			for (int i = 0; i < 256; i++)
			begin
				dataMem_q[i] <= 8'h00;
			end
		end
		else if (bitMid)
		begin
			for (int s = 0; s < STREAMS; s++)
			begin
				rxShift_q[s] <= {rxShift_q[s][5:0], serialInStream[s]};
				if (bitNum == `TCX_LAST_BIT)
				begin
					dataMem_q[chanIndex(3'(s), chanNum)] <=
						{rxShift_q[s], serialInStream[s]};
				end
			end
		end
	end

	// any number of outputs may address the same data byte at once
	function automatic logic [7:0] outByte(input logic [7:0] oIdx);
		logic msg;
		msg = controlReg_q[`TCX_CTRL_MSG_BIT] | connHigh_q[oIdx][`TCX_CMH_MODE_BIT];
		return msg ? connLow_q[oIdx] : dataMem_q[connLow_q[oIdx]];
	endfunction : outByte

	function automatic logic outDrive(input logic [7:0] oIdx);
		return controlReg_q[`TCX_CTRL_MSG_BIT] | connHigh_q[oIdx][`TCX_CMH_DRIVE_BIT];
	endfunction : outDrive

	// per-stream choice for the channel about to start; unused streams stay quiet
	always_comb
	begin
		for (int s = 0; s < 8; s++)
		begin
			txLoad[s]     = 8'h00;
			txDrive[s]    = 1'b0;
			txCtrlNext[s] = 1'b0;
			if (s < STREAMS)
			begin
				txLoad[s]     = outByte(chanIndex(3'(s), chanNum));
				txDrive[s]    = outDrive(chanIndex(3'(s), chanNum));
				txCtrlNext[s] = connHigh_q[chanIndex(3'(s), chanNum)][`TCX_CMH_CTRL_BIT];
			end
		end
	end

	// transmit side: each channel's byte is chosen at its first bit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < 8; s++)
			begin
				txShift_q[s] <= 8'h00;
			end
			txOe_q   <= 8'h00;
			txCtrl_q <= 8'h00;
		end
		else if (chanStart)
		begin
			for (int s = 0; s < STREAMS; s++)
			begin
				txShift_q[s] <= txLoad[s];
			end
			txOe_q   <= txDrive;
			txCtrl_q <= txCtrlNext;
		end
		else if (bitStart)
		begin
			for (int s = 0; s < STREAMS; s++)
			begin
				txShift_q[s] <= {txShift_q[s][6:0], 1'b0};
			end
		end
	end

	always_comb
	begin
		for (int s = 0; s < 8; s++)
		begin
			serialOutStream[s] = txShift_q[s][7];
		end
	end
	assign serialOutOe       = txOe_q;
	assign extChannelCtrlOut = FULL_SIZE ? txCtrl_q : 8'h00;

	// host port
	assign hostStart = (hostState_q == tcx_pkg::HOST_IDLE)
		& hostReq.dataStrobe & ~hostReq.chipSelectN;
	assign hostEnd   = (hostState_q == tcx_pkg::HOST_ACK) & ~hostReq.dataStrobe;
	assign rdBlock   = pickBlock(controlReg_q, 1'b1);
	assign wrBlock   = pickBlock(controlReg_q, 1'b0);
	assign hostIndex = chanIndex(controlReg_q[`TCX_CTRL_SEG_HI:0], hostReq.hostAddr[4:0]);

	// read value chosen when the cycle is taken; data memory readable in any mode
	always_comb
	begin
		rdValue = controlReg_q;
		if (hostReq.hostAddr[`TCX_ADDR_MEM_BIT])
		begin
			case (rdBlock)
				`TCX_BLK_DATA:      rdValue = dataMem_q[hostIndex];
				`TCX_BLK_CONN_LOW:  rdValue = connLow_q[hostIndex];
				`TCX_BLK_CONN_HIGH: rdValue = {5'h00, connHigh_q[hostIndex]};
				default:            rdValue = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hostState_q <= tcx_pkg::HOST_IDLE;
			isRead_q    <= 1'b0;
			addr_q      <= 6'h00;
			wrData_q    <= 8'h00;
			rdData_q    <= 8'h00;
		end
		else
		begin
			case (hostState_q)
				tcx_pkg::HOST_IDLE:
				begin
					if (hostStart)
					begin
						hostState_q <= tcx_pkg::HOST_ACK;
						isRead_q    <= hostReq.readNotWrite;
						addr_q      <= hostReq.hostAddr;
						rdData_q    <= rdValue;
						// a host that drops strobe right after the ack still writes
						wrData_q    <= hostReq.wrData;
					end
				end
				tcx_pkg::HOST_ACK:
				begin
					if (hostReq.dataStrobe)
					begin
						wrData_q <= hostReq.wrData;
					end
					else
					begin
						hostState_q <= tcx_pkg::HOST_IDLE;
					end
				end
				default:
				begin
					hostState_q <= tcx_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// write decode uses the address latched when the cycle was taken
	assign wrCommit  = hostEnd & ~isRead_q;
	assign wrIndex   = chanIndex(controlReg_q[`TCX_CTRL_SEG_HI:0], addr_q[4:0]);

	// host writes land when the strobe falls, using the last data seen while it was high
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			controlReg_q <= `TCX_CTRL_RESET;
			for (int i = 0; i < 256; i++)
			begin
				connLow_q[i]  <= 8'h00;
				connHigh_q[i] <= 3'h0;
			end
		end
		else if (wrCommit)
		begin
			if (!addr_q[`TCX_ADDR_MEM_BIT])
			begin
				controlReg_q <= wrData_q;
			end
			else if (wrBlock == `TCX_BLK_CONN_LOW)
			begin
				connLow_q[wrIndex] <= wrData_q;
			end
			else if (wrBlock == `TCX_BLK_CONN_HIGH)
			begin
				connHigh_q[wrIndex] <= wrData_q[2:0];
			end
		end
	end

	// bus drive only while strobe is high inside an acknowledged read
	assign ackOutN   = (hostState_q != tcx_pkg::HOST_ACK);
	assign driveData = (hostState_q == tcx_pkg::HOST_ACK)
		& isRead_q & hostReq.dataStrobe;
	assign hostRsp   = '{transferAckN: ackOutN,
		dataOe:       driveData,
		rdData:       rdData_q};

endmodule : tcx_switch

// ---- hw/tcx_defs.svh ----
// constants for the timeslot crosspoint switch
`ifndef TCX_DEFS_SVH
`define TCX_DEFS_SVH

`define TCX_CTRL_RESET       8'h00
`define TCX_CTRL_SPLIT_BIT   7
`define TCX_CTRL_MSG_BIT     6
`define TCX_CTRL_BLK_HI      4
`define TCX_CTRL_BLK_LO      3
`define TCX_CTRL_SEG_HI      2
`define TCX_ADDR_MEM_BIT     5
`define TCX_BLK_DATA         2'h1
`define TCX_BLK_CONN_LOW     2'h2
`define TCX_BLK_CONN_HIGH    2'h3
`define TCX_CMH_DRIVE_BIT    0
`define TCX_CMH_CTRL_BIT     1
`define TCX_CMH_MODE_BIT     2
`define TCX_CHANNELS         32
`define TCX_BITS_PER_CHAN    8
`define TCX_FULL_STREAMS     8
`define TCX_SMALL_STREAMS    4
`define TCX_LAST_BIT         3'h7
`define TCX_CHAN_START       4'h0

`endif

// ---- hw/tcx_pkg.sv ----
// types shared by the timeslot crosspoint switch
package tcx_pkg;

	typedef struct packed {
		logic       dataStrobe;
		logic       chipSelectN;
		logic       readNotWrite;
		logic [5:0] hostAddr;
		logic [7:0] wrData;
	} tcx_host_req_t;

	typedef struct packed {
		logic       transferAckN;
		logic       dataOe;
		logic [7:0] rdData;
	} tcx_host_rsp_t;

	typedef enum logic [0:0] {
		HOST_IDLE = 1'b0,
		HOST_ACK  = 1'b1
	} tcx_host_state_t;

endpackage : tcx_pkg

// ---- test/tcx_tdm_source.sv ----
// far-side model: free-running bit clock, frame pulse and input streams
`timescale 1ns/1ns
module tcx_tdm_source (
	output logic       bitClock4xN,
	output logic       framePulseN,
	output logic [7:0] serialInStream
);
	logic [8:0] nxt;
	logic [7:0] pat;

	// levels change on the rising edge so every falling edge sees them settled
	initial
	begin
		bitClock4xN = 1'b1;
		framePulseN = 1'b1;
		serialInStream = 8'h00;
		nxt = 9'h1ff;
		forever
		begin
			#122 bitClock4xN = 1'b1;
			nxt = nxt + 9'h001; // 512 falls, two per bit
			framePulseN = (nxt != 9'h000);
			for (int s = 0; s < 8; s++)
			begin
				pat = {3'(s), nxt[8:4]} ^ 8'h5a;
				if (!nxt[0])
					serialInStream[s] = pat[3'h7 - nxt[3:1]]; // msb first
			end
			#122 bitClock4xN = 1'b0;
		end
	end
endmodule : tcx_tdm_source

// ---- test/tcx_switch_monitor.sv ----
// port assertions for the timeslot crosspoint switch
`timescale 1ns/1ns
module tcx_switch_monitor #(
	parameter int STREAMS = 8
) (
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire logic [7:0]             serialOutStream,
	input wire logic [7:0]             serialOutOe,
	input wire logic [7:0]             extChannelCtrlOut,
	input wire tcx_pkg::tcx_host_req_t hostReq,
	input wire tcx_pkg::tcx_host_rsp_t hostRsp
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire ackN = hostRsp.transferAckN;
	wire stb  = hostReq.dataStrobe;

	property p_take; ackN && stb && !hostReq.chipSelectN |=> !ackN; endproperty
	a_take: assert property (p_take) else $error("request not acknowledged");
	property p_cs; ackN && hostReq.chipSelectN |=> ackN; endproperty
	a_cs: assert property (p_cs) else $error("deselected request answered");
	property p_hold; !ackN && stb |=> !ackN; endproperty
	a_hold: assert property (p_hold) else $error("ack dropped early");
	property p_end; !ackN && !stb |=> ackN; endproperty
	a_end: assert property (p_end) else $error("ack not released");
	property p_oe; hostRsp.dataOe == (!ackN && stb && hostReq.readNotWrite); endproperty
	a_oe: assert property (p_oe) else $error("data bus drive wrong");
	property p_rd; !ackN && $past(!ackN) |-> $stable(hostRsp.rdData); endproperty
	a_rd: assert property (p_rd) else $error("read data moved in cycle");
	property p_ext; STREAMS == 4 |-> extChannelCtrlOut == 8'h00; endproperty
	a_ext: assert property (p_ext) else $error("control output in small size");
	property p_bit; $changed(serialOutStream) |=> $stable(serialOutStream) [*4]; endproperty
	a_bit: assert property (p_bit) else $error("output bit too short");
	property p_oech; $changed(serialOutOe) |=> $stable(serialOutOe) [*8]; endproperty
	a_oech: assert property (p_oech) else $error("enable not per channel");

	c_read: cover property (hostRsp.dataOe);
	c_write: cover property (!ackN && !hostReq.readNotWrite);
	c_hiz: cover property ($fell(serialOutOe[3]));
endmodule : tcx_switch_monitor

bind tcx_switch tcx_switch_monitor #(.STREAMS(STREAMS)) mon (
	.core_clk(core_clk), .rst(rst), .serialOutStream(serialOutStream),
	.serialOutOe(serialOutOe), .extChannelCtrlOut(extChannelCtrlOut),
	.hostReq(hostReq), .hostRsp(hostRsp)
);

// ---- test/tcx_switch_bench.sv ----
// self-checking bench for the timeslot crosspoint switch
`timescale 1ns/1ns
module tcx_switch_bench;
	logic                   core_clk;
	logic                   rst;
	logic                   bitClock4xN;
	logic                   framePulseN;
	logic [7:0]             serialInStream;
	logic [7:0]             serialOutStream;
	logic [7:0]             serialOutOe;
	logic [7:0]             extChannelCtrlOut;
	tcx_pkg::tcx_host_req_t hostReq;
	tcx_pkg::tcx_host_rsp_t hostRsp;
	logic [8:0]             expQ[$];
	logic [8:0]             cnt;
	logic [8:0]             seen;
	logic [7:0]             sh;
	logic [7:0]             r;
	logic [2:0]             wS;
	logic [4:0]             wC;
	logic                   wOn;
	logic                   oeAll;
	logic                   ackQ;
	logic                   ctlExp;
	logic [7:0]             smallCtrl;
	int                     fail_count;
	int                     tests_run;
	int                     seed;

	tcx_switch dut (.core_clk(core_clk), .rst(rst), .bitClock4xN(bitClock4xN),
		.framePulseN(framePulseN), .serialInStream(serialInStream),
		.serialOutStream(serialOutStream), .serialOutOe(serialOutOe),
		.extChannelCtrlOut(extChannelCtrlOut), .hostReq(hostReq), .hostRsp(hostRsp));
	tcx_tdm_source src (.bitClock4xN(bitClock4xN), .framePulseN(framePulseN),
		.serialInStream(serialInStream));
	// reduced size shares every input so its channel control output can be held at zero
	tcx_switch #(.STREAMS(4)) dutSmall (.core_clk(core_clk), .rst(rst),
		.bitClock4xN(bitClock4xN), .framePulseN(framePulseN), .serialInStream(serialInStream),
		.serialOutStream(), .serialOutOe(), .extChannelCtrlOut(smallCtrl),
		.hostReq(hostReq), .hostRsp());

	task check(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// strobe is held until ack is seen low or 20 clocks pass, then dropped together with select
	task host(input logic rw, input logic [5:0] a, input logic [7:0] d, input logic csN);
		@(negedge core_clk);
		hostReq = '{1'b1, csN, rw, a, d};
		for (int n = 0; n < 20 && hostRsp.transferAckN !== 1'b0; n++)
			@(negedge core_clk);
		hostReq.dataStrobe = 1'b0;
		hostReq.chipSelectN = 1'b1;
		for (int n = 0; n < 20 && hostRsp.transferAckN !== 1'b1; n++)
			@(negedge core_clk);
	endtask : host

	task wr(input logic [5:0] a, input logic [7:0] d);
		host(1'b0, a, d, 1'b0);
	endtask : wr

	task rd(input logic [5:0] a, input logic [7:0] e);
		expQ.push_back({1'b0, e});
		host(1'b1, a, 8'h00, 1'b0);
	endtask : rd

	// watching starts at a frame pulse so no byte is caught half way
	task watch(input logic [2:0] s, input logic [4:0] c, input logic [8:0] e, input int n);
		wS = s;
		wC = c;
		repeat (n) expQ.push_back(e);
		@(negedge framePulseN);
		wOn = 1'b1;
		while (expQ.size() != 0)
			@(negedge bitClock4xN);
		wOn = 1'b0;
	endtask : watch

	always @(negedge core_clk)
	begin
		if (ackQ === 1'b1 && hostRsp.transferAckN === 1'b0 && hostReq.readNotWrite)
			check({1'b0, hostRsp.rdData}, expQ.pop_front());
		ackQ = hostRsp.transferAckN;
	end

	always @(negedge bitClock4xN)
	begin
		cnt = framePulseN ? cnt + 9'h001 : 9'h000;
		if (wOn && cnt[0] && cnt[8:4] == wC)
		begin
			if (cnt[3:1] == 3'h0)
				oeAll = 1'b1;
			oeAll = oeAll & serialOutOe[wS];
			sh = {sh[6:0], serialOutStream[wS]};
			seen = {oeAll, oeAll ? sh : 8'h00};
			if (cnt[3:1] == 3'h7)
			begin
				check(seen, expQ.pop_front());
				check({extChannelCtrlOut[wS], smallCtrl}, {ctlExp, 8'h00});
			end
		end
	end

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		#3000000;
		fail_count++;
		test_done();
	end

	initial
	begin
		seed = 59;
		fail_count = 0;
		tests_run = 0;
		wOn = 1'b0;
		cnt = 9'h000;
		ackQ = 1'b1;
		ctlExp = 1'b0;
		hostReq = '{1'b0, 1'b1, 1'b0, 6'h00, 8'h00};
		rst = 1'b1;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		check({hostRsp.transferAckN, serialOutOe}, 9'h100);
		repeat (2) @(negedge framePulseN);
		wr(6'h00, 8'h0b);
		host(1'b0, 6'h00, 8'h1f, 1'b1);
		rd(6'h00, 8'h0b);
		for (int i = 0; i < 4; i++)
		begin
			r = 8'($random(seed));
			wr(6'h00, {5'h01, r[7:5]});
			rd({1'b1, r[4:0]}, r ^ 8'h5a);
		end
		r = 8'($random(seed));
		for (int s = 1; s < 3; s++)
		begin
			wr(6'h00, {5'h02, 3'(s)});
			wr(6'h23, r);
			wr(6'h00, {5'h03, 3'(s)});
			wr(6'h23, 8'h01);
		end
		rd(6'h23, 8'h01);
		watch(3'h1, 5'h03, {1'b1, r ^ 8'h5a}, 1);
		watch(3'h2, 5'h03, {1'b1, r ^ 8'h5a}, 1);
		r = 8'($random(seed));
		wr(6'h00, 8'h13);
		wr(6'h27, r);
		wr(6'h00, 8'h1b);
		wr(6'h27, 8'hff);
		rd(6'h27, 8'h07);
		ctlExp = 1'b1;
		watch(3'h3, 5'h07, {1'b1, r}, 2);
		ctlExp = 1'b0;
		watch(3'h4, 5'h09, 9'h000, 1);
		r = 8'($random(seed));
		wr(6'h00, 8'h14);
		wr(6'h29, r);
		wr(6'h00, 8'h54);
		watch(3'h4, 5'h09, {1'b1, r}, 1);
		test_done();
	end
endmodule : tcx_switch_bench
